//--- src/pudc_control.sv
// ****************************************************************
// controlling logic: makes the count clock, drives the control pins
// and forms the look-ahead inhibit for one stage
// ****************************************************************
module pudc_control
   import pudc_pkg::*;
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_arst_n,
   // user requests
   input wire logic i_enable,
   input wire logic i_carry_in,
   input wire logic i_down,
   input wire logic i_load,
   input wire logic [3:0] i_preset,
   // user status
   output logic [3:0] o_count,
   output logic o_carry_out,
   // link pins
   pudc_link_if.ctl link
);

   // ****************************************************************
   // count clock divider
   // ****************************************************************

   logic [7:0] div;
   logic [7:0] next_div;
   logic clk_out;
   logic next_clk_out;

   // square count clock, equal phases, low phase long enough for ripple
   always_comb begin
      next_div = 8'(div + PUDC_DIV_ONE);
      next_clk_out = clk_out;
      if (next_div >= PUDC_HALF_CYCLES) begin
         next_div = PUDC_DIV_ZERO;
         next_clk_out = ~clk_out;
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         div <= PUDC_DIV_ZERO;
         clk_out <= 1'h0;
      end else begin
         div <= next_div;
         clk_out <= next_clk_out;
      end
   end

   // ****************************************************************
   // control pins
   // ****************************************************************

   logic load_n;
   logic next_load_n;
   logic [3:0] preset;
   logic [3:0] next_preset;
   logic inhibit;
   logic next_inhibit;
   logic down;
   logic next_down;

   // inhibit built from global enable and preceding stage flags
   always_comb begin
      next_load_n = ~i_load;
      next_preset = i_preset;
      next_inhibit = ~(i_enable & i_carry_in);
      next_down = i_down ? PUDC_DIR_DOWN : PUDC_DIR_UP;
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         load_n <= 1'h1;
         preset <= PUDC_ZERO;
         inhibit <= PUDC_INHIBIT_ON;
         down <= PUDC_DIR_UP;
      end else begin
         load_n <= next_load_n;
         preset <= next_preset;
         inhibit <= next_inhibit;
         down <= next_down;
      end
   end

   // ****************************************************************
   // status back to the user
   // ****************************************************************

   logic [3:0] count;
   logic [3:0] next_count;
   logic carry;
   logic next_carry;

   // flag is sampled as a level, never used as a clock
   always_comb begin
      next_count = link.count_out;
      next_carry = link.terminal_flag & i_enable & i_carry_in;
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         count <= PUDC_ZERO;
         carry <= 1'h0;
      end else begin
         count <= next_count;
         carry <= next_carry;
      end
   end

   assign link.count_clock = clk_out;
   assign link.load_n = load_n;
   assign link.preset_in = preset;
   assign link.count_inhibit = inhibit;
   assign link.down_sel = down;
   assign o_count = count;
   assign o_carry_out = carry;

endmodule : pudc_control

//--- src/pudc_counter.sv
// How it works
// - four state bits, change only synchronously
// - low load copies preset regardless of others
// - count only on rising count clock
// - inhibit high stops counting entirely
// - direction low up, high down, sampled
// - flag high at zero down or max up
// - flag holds until count or direction change
// - flag ignores own count inhibit
// - ripple low during clock low phase
// - ripple high when inhibited or flag low
// - never clock anything from terminal flag
// - ripple cascade: ripple clocks next stage
// - clock low phase covers carry ripple
// - look-ahead inhibit from preceding flags, enable
module pudc_counter
   import pudc_pkg::*;
#(
   parameter bit DECADE = 1'b1
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_arst_n,
   // link pins
   pudc_link_if.dev link,
   // user side status
   output logic [3:0] o_count_value,
   output pudc_mode_t o_mode,
   output logic o_wrap
);

   // ****************************************************************
   // range selection
   // ****************************************************************

   // top of the count range picked at build time
   localparam logic [3:0] MAX_COUNT = DECADE ? PUDC_MAX_DECADE : PUDC_MAX_BINARY;

   // ****************************************************************
   // state
   // ****************************************************************

   logic [3:0] count;
   logic [3:0] next_count;
   logic terminal;
   logic next_terminal;
   logic ripple_n;
   logic next_ripple_n;
   logic clock_seen;
   logic next_clock_seen;
   pudc_mode_t mode;
   pudc_mode_t next_mode;
   logic wrap;
   logic next_wrap;

   // ****************************************************************
   // input decode
   // ****************************************************************

   logic rise;
   logic counting;
   logic loading;
   logic at_top;
   logic at_bottom;

   // rising edge of the sampled count clock, falling edge ignored
   assign rise = link.count_clock & ~clock_seen;

   // load request is a synchronous input here, so it is already aligned
   assign loading = ~link.load_n;

   // counting needs a rising edge, no inhibit and no load
   assign counting = rise & (link.count_inhibit != PUDC_INHIBIT_ON) & ~loading;

   // end-of-range decode on the present state
   assign at_top = (count == MAX_COUNT);
   assign at_bottom = (count == PUDC_ZERO);

   // ****************************************************************
   // count clock edge tracker
   // ****************************************************************

   // remembers the last level of the count clock
   always_comb begin
      next_clock_seen = link.count_clock;
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         // taken as high, so a pin that idles high (a ripple clock from a
         // lower stage) is not mistaken for a rising edge after reset
         clock_seen <= 1'h1;
      end else begin
         clock_seen <= next_clock_seen;
      end
   end

   // ****************************************************************
   // mode decode
   // ****************************************************************

   // classifies what happens in this cycle, load first
   always_comb begin
      next_mode = PUDC_HOLD;
      if (loading) begin
         next_mode = PUDC_LOAD;
      end else if (counting && link.down_sel == PUDC_DIR_DOWN) begin
         next_mode = PUDC_DOWN;
      end else if (counting) begin
         next_mode = PUDC_UP;
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mode <= PUDC_HOLD;
      end else begin
         mode <= next_mode;
      end
   end

   // ****************************************************************
   // count state
   // ****************************************************************

   // steps, wraps or presets the four state bits
   always_comb begin
      next_count = count;
      next_wrap = 1'h0;
      case (next_mode)
         PUDC_LOAD: begin
            next_count = link.preset_in;
         end
         PUDC_UP: begin
            // direction low counts up, sampled at the edge
            if (at_top) begin
               next_count = PUDC_ZERO;
               next_wrap = 1'h1;
            end else begin
               next_count = 4'(count + PUDC_ONE);
            end
         end
         PUDC_DOWN: begin
            // direction high counts down
            if (at_bottom) begin
               next_count = MAX_COUNT;
               next_wrap = 1'h1;
            end else begin
               next_count = 4'(count - PUDC_ONE);
            end
         end
         PUDC_HOLD: begin
            next_count = count;
         end
         default: begin
            next_count = count;
         end
      endcase
   end

   // state changes only at the system clock edge
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         count <= PUDC_RESET_COUNT;
         wrap <= 1'h0;
      end else begin
         count <= next_count;
         wrap <= next_wrap;
      end
   end

   // ****************************************************************
   // terminal flag
   // ****************************************************************

   // decoded from the coming state and the present direction only,
   // so inhibit never reaches it and it follows a direction change
   always_comb begin
      if (link.down_sel == PUDC_DIR_DOWN) begin
         next_terminal = (next_count == PUDC_ZERO);
      end else begin
         next_terminal = (next_count == MAX_COUNT);
      end
   end

   // registered, so it holds steady until count or direction moves
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         terminal <= 1'h0;
      end else begin
         terminal <= next_terminal;
      end
   end

   // ****************************************************************
   // ripple output
   // ****************************************************************

   // copies the low phase of the count clock while at terminal state
   always_comb begin
      next_ripple_n = 1'h1;
      if (terminal && link.count_inhibit != PUDC_INHIBIT_ON && !link.count_clock) begin
         next_ripple_n = 1'h0;
      end
   end

   // goes high again once the count clock has risen
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ripple_n <= 1'h1;
      end else begin
         ripple_n <= next_ripple_n;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************

   // all outputs straight from flip-flops
   assign link.count_out = count;
   assign link.terminal_flag = terminal;
   assign link.ripple_pulse_n = ripple_n;
   assign o_count_value = count;
   assign o_mode = mode;
   assign o_wrap = wrap; // one cycle pulse per wrap

endmodule : pudc_counter

//--- src/pudc_link_if.sv
// ****************************************************************
// pins between the counter stage and its controlling logic
// ****************************************************************
interface pudc_link_if;
   // count clock from the controlling end
   logic count_clock;
   // parallel preset
   logic [3:0] preset_in;
   logic load_n;
   // count control
   logic count_inhibit;
   logic down_sel;
   // stage outputs
   logic [3:0] count_out;
   logic terminal_flag;
   logic ripple_pulse_n;

   // counter stage side
   modport dev (
      input count_clock, preset_in, load_n, count_inhibit, down_sel,
      output count_out, terminal_flag, ripple_pulse_n
   );

   // controlling logic side
   modport ctl (
      output count_clock, preset_in, load_n, count_inhibit, down_sel,
      input count_out, terminal_flag, ripple_pulse_n
   );
endinterface : pudc_link_if

//--- src/pudc_pkg.sv
// ****************************************************************
// shared constants of the up/down counter stage
// ****************************************************************
package pudc_pkg;

   // ****************************************************************
   // count state
   // ****************************************************************
   localparam int PUDC_WIDTH = 4;
   localparam logic [3:0] PUDC_ZERO = 4'h0;
   localparam logic [3:0] PUDC_ONE = 4'h1;
   localparam logic [3:0] PUDC_MAX_DECADE = 4'h9;
   localparam logic [3:0] PUDC_MAX_BINARY = 4'hF;
   localparam logic [3:0] PUDC_RESET_COUNT = 4'h0;

   // ****************************************************************
   // pin levels
   // ****************************************************************
   localparam logic PUDC_DIR_UP = 1'h0;
   localparam logic PUDC_DIR_DOWN = 1'h1;
   localparam logic PUDC_INHIBIT_ON = 1'h1;

   // ****************************************************************
   // timing of the count clock made by the controlling end
   // ****************************************************************
   localparam int PUDC_CLOCK_PERIOD_NS = 10;
   localparam int PUDC_COUNT_PERIOD_NS = 80;
   localparam int PUDC_COUNT_PERIOD_CYCLES = PUDC_COUNT_PERIOD_NS / PUDC_CLOCK_PERIOD_NS;
   localparam int PUDC_HALF_CYCLES_INT = (PUDC_COUNT_PERIOD_CYCLES / 2 < 1) ? 1 : PUDC_COUNT_PERIOD_CYCLES / 2;
   localparam logic [7:0] PUDC_HALF_CYCLES = 8'(PUDC_HALF_CYCLES_INT);
   localparam logic [7:0] PUDC_DIV_ONE = 8'h01;
   localparam logic [7:0] PUDC_DIV_ZERO = 8'h00;

   // ****************************************************************
   // operating mode, one-hot
   // ****************************************************************
   typedef enum logic [3:0] {
      PUDC_HOLD = 4'h1,
      PUDC_LOAD = 4'h2,
      PUDC_UP   = 4'h4,
      PUDC_DOWN = 4'h8
   } pudc_mode_t;

endpackage : pudc_pkg

//--- verification/pudc_properties.sv
// ********************************
// link pin checks for one stage
// ********************************
module pudc_properties
   import pudc_pkg::*;
#(
   parameter bit DECADE = 1'b1
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_arst_n,
   // link pins
   input wire logic count_clock,
   input wire logic [3:0] preset_in,
   input wire logic load_n,
   input wire logic count_inhibit,
   input wire logic down_sel,
   input wire logic [3:0] count_out,
   input wire logic terminal_flag,
   input wire logic ripple_pulse_n
);
   logic clk_q;
   logic rise;
   logic [3:0] top;

   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);

   // last count clock level, for rise detection
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         clk_q <= 1'b0;
      end else begin
         clk_q <= count_clock;
      end
   end

   // edge that must count, and top of range
   assign rise = count_clock & ~clk_q & load_n & ~count_inhibit;
   assign top = DECADE ? PUDC_MAX_DECADE : PUDC_MAX_BINARY;

   property p_load;
      !load_n |=> count_out == $past(preset_in);
   endproperty
   a_load: assert property (p_load) else $error("preset not taken");
   property p_up;
      rise && !down_sel |=> count_out == (($past(count_out) == top) ? PUDC_ZERO : $past(count_out) + PUDC_ONE);
   endproperty
   a_up: assert property (p_up) else $error("bad up count");
   property p_down;
      rise && down_sel |=> count_out == (($past(count_out) == PUDC_ZERO) ? top : $past(count_out) - PUDC_ONE);
   endproperty
   a_down: assert property (p_down) else $error("bad down count");
   property p_hold;
      load_n && !rise |=> $stable(count_out);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved");
   property p_flag;
      terminal_flag == ($past(down_sel) ? count_out == PUDC_ZERO : count_out == top);
   endproperty
   a_flag: assert property (p_flag) else $error("bad terminal flag");
   property p_ripple_low;
      terminal_flag && !count_inhibit && !count_clock |=> !ripple_pulse_n;
   endproperty
   a_ripple_low: assert property (p_ripple_low) else $error("ripple missing");
   property p_ripple_rise;
      count_clock |=> ripple_pulse_n;
   endproperty
   a_ripple_rise: assert property (p_ripple_rise) else $error("ripple low in high phase");
   property p_ripple_idle;
      count_inhibit || !terminal_flag |=> ripple_pulse_n;
   endproperty
   a_ripple_idle: assert property (p_ripple_idle) else $error("ripple not idle");
endmodule : pudc_properties

//--- verification/test_presettable_updown_counter.sv
module test_presettable_updown_counter
   import pudc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clock = 1'b0;
   logic i_arst_n = 1'b0;
   logic en, cin, down, load;
   logic [3:0] pre [2];
   int n_fail = 0;
   int comparisons = 0;
   int seed = 32'hA40E2E4C;

   // ********************************
   // clock and shared tasks
   // ********************************
   always #5 i_clock = ~i_clock;

   // compare one result
   task automatic check(input logic [3:0] got, input logic [3:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic step(input int n);
      repeat (n) @(negedge i_clock);
   endtask : step

   // count of one stage after a counting edge, wrapping at both ends
   function automatic logic [3:0] next_val(input logic [3:0] cnt, input logic dn, input logic [3:0] top);
      if (dn) begin
         return (cnt == PUDC_ZERO) ? top : 4'(cnt - PUDC_ONE);
      end
      return (cnt == top) ? PUDC_ZERO : 4'(cnt + PUDC_ONE);
   endfunction : next_val

   task automatic print_verdict;
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   // ********************************
   // decade lane 0, binary lane 1
   // ********************************
   for (genvar g = 0; g < 2; g++) begin : lane
      localparam logic [3:0] TOP = (g == 0) ? PUDC_MAX_DECADE : PUDC_MAX_BINARY;
      logic [3:0] cval, ocnt, e_cnt, e_mode, e_ocnt;
      pudc_mode_t mode;
      logic wrap, cy, e_tf, e_wrap, e_cy, e_ld, e_dn, clk_q, rise;
      logic [3:0] e_hi;
      logic rp_q, hi_rise;
      pudc_link_if link ();
      pudc_link_if link2 ();
      pudc_control pudc_control_i (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_enable(en), .i_carry_in(cin),
         .i_down(down), .i_load(load), .i_preset(pre[g]), .o_count(ocnt), .o_carry_out(cy), .link(link));
      pudc_counter #(.DECADE(g == 0)) pudc_counter_i (.i_clock(i_clock), .i_arst_n(i_arst_n), .link(link),
         .o_count_value(cval), .o_mode(mode), .o_wrap(wrap));
      pudc_properties #(.DECADE(g == 0)) pudc_properties_i (.i_clock(i_clock), .i_arst_n(i_arst_n),
         .count_clock(link.count_clock), .preset_in(link.preset_in), .load_n(link.load_n),
         .count_inhibit(link.count_inhibit), .down_sel(link.down_sel), .count_out(link.count_out),
         .terminal_flag(link.terminal_flag), .ripple_pulse_n(link.ripple_pulse_n));

      // second stage clocked by the first stage's ripple output, never inhibited itself
      assign link2.count_clock = link.ripple_pulse_n;
      assign link2.preset_in = link.preset_in;
      assign link2.load_n = link.load_n;
      assign link2.count_inhibit = ~PUDC_INHIBIT_ON;
      assign link2.down_sel = link.down_sel;
      if (1) begin : upper
         pudc_counter #(.DECADE(g == 0)) pudc_counter_i (.i_clock(i_clock), .i_arst_n(i_arst_n), .link(link2),
            .o_count_value(), .o_mode(), .o_wrap());
      end

      // model from the pins before the edge, compared once the edge settles
      always @(posedge i_clock) begin
         if (!i_arst_n) begin
            e_cnt = PUDC_ZERO;
            clk_q = 1'b0;
            e_hi = PUDC_ZERO;
            rp_q = 1'b1;
         end else begin
            e_ocnt = link.count_out;
            e_cy = link.terminal_flag & en & cin;
            e_ld = ~load;
            e_dn = down;
            rise = link.count_clock & ~clk_q & ~link.count_inhibit & link.load_n;
            clk_q = link.count_clock;
            e_wrap = rise & (link.down_sel ? e_cnt == PUDC_ZERO : e_cnt == TOP);
            e_mode = !link.load_n ? PUDC_LOAD : !rise ? PUDC_HOLD : link.down_sel ? PUDC_DOWN : PUDC_UP;
            if (!link.load_n) begin
               e_cnt = link.preset_in;
            end else if (rise) begin
               e_cnt = next_val(e_cnt, link.down_sel, TOP);
            end
            e_tf = link.down_sel ? e_cnt == PUDC_ZERO : e_cnt == TOP;
            // second stage counts on each rise of the first stage's ripple output
            hi_rise = link.ripple_pulse_n & ~rp_q & link.load_n;
            rp_q = link.ripple_pulse_n;
            if (!link.load_n) begin
               e_hi = link.preset_in;
            end else if (hi_rise) begin
               e_hi = next_val(e_hi, link.down_sel, TOP);
            end
            #2;
            check(link.count_out, e_cnt, "count");
            check(cval, e_cnt, "count value");
            check(mode, e_mode, "mode");
            check(wrap, e_wrap, "wrap");
            check(link.terminal_flag, e_tf, "flag");
            check(ocnt, e_ocnt, "echo");
            check(cy, e_cy, "carry");
            check(link2.count_out, e_hi, "cascade");
            check(link.load_n, e_ld, "load pin");
            check(link.down_sel, e_dn, "direction pin");
         end
      end
   end

   // ********************************
   // stimulus
   // ********************************
   task automatic load_val(input logic [3:0] d0, input logic [3:0] d1);
      pre[0] = d0;
      pre[1] = d1;
      load = 1'b1;
      step(2);
      load = 1'b0;
      step(1);
   endtask : load_val

   // hang guard
   initial begin
      #100000;
      n_fail++;
      $display("CHECK FAILED at %0t: watchdog", $time);
      print_verdict();
   end

   // main sequence
   initial begin
      en = 1'b0;
      cin = 1'b1;
      down = 1'b0;
      load = 1'b0;
      pre[0] = 4'h0;
      pre[1] = 4'h0;
      step(6);
      i_arst_n = 1'b1;
      for (int v = 0; v < 16; v++) begin
         load_val(4'(v % 10), 4'(v));
      end
      $display("test load done");
      load_val(4'h8, 4'hE);
      en = 1'b1;
      step(40);
      down = 1'b1;
      step(40);
      $display("test wrap done");
      en = 1'b0;
      load_val(4'h9, 4'hF);
      down = 1'b0;
      step(12);
      down = 1'b1;
      step(4);
      down = 1'b0;
      en = 1'b1;
      cin = 1'b0;
      step(12);
      $display("test flag done");
      for (int i = 0; i < 1800; i++) begin
         en = ($random(seed) & 3) != 0;
         cin = ($random(seed) & 7) != 0;
         if (($random(seed) & 31) == 0) down = ~down;
         load = ($random(seed) & 31) == 0;
         pre[1] = 4'($random(seed));
         pre[0] = 4'(pre[1] % 10);
         if (i == 900) i_arst_n = 1'b0;
         if (i == 903) i_arst_n = 1'b1;
         step(1);
      end
      $display("test random done");
      print_verdict();
   end
endmodule : test_presettable_updown_counter
